// ---- rtl/poc_pkg.sv ----
// Package for the pin ownership and parallel I/O control block.
// Assumes a 32-bit APB slave with word-aligned registers.
package poc_pkg;
  localparam int NPINS = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_OWN_SET = 8'h00;
  localparam logic [7:0] OFS_OWN_CLR = 8'h04;
  localparam logic [7:0] OFS_OWN_STS = 8'h08;
  localparam logic [7:0] OFS_OE_SET = 8'h10;
  localparam logic [7:0] OFS_OE_CLR = 8'h14;
  localparam logic [7:0] OFS_OE_STS = 8'h18;
  localparam logic [7:0] OFS_FLT_SET = 8'h20;
  localparam logic [7:0] OFS_FLT_CLR = 8'h24;
  localparam logic [7:0] OFS_FLT_STS = 8'h28;
  localparam logic [7:0] OFS_OD_SET = 8'h30;
  localparam logic [7:0] OFS_OD_CLR = 8'h34;
  localparam logic [7:0] OFS_OD_STS = 8'h38;
  localparam logic [7:0] OFS_PIN_STS = 8'h3C;
  localparam logic [7:0] OFS_IRQ_SET = 8'h40;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h44;
  localparam logic [7:0] OFS_IRQ_STS = 8'h48;
  localparam logic [7:0] OFS_CHG_STS = 8'h4C;
  localparam logic [7:0] OFS_MD_SET = 8'h50;
  localparam logic [7:0] OFS_MD_CLR = 8'h54;
  localparam logic [7:0] OFS_MD_STS = 8'h58;
  // Reset values
  localparam logic [31:0] RST_OWN = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  // One control property: write-1 set, write-1 clear, readable state
  typedef struct packed {
    logic [31:0] own;
    logic [31:0] oe;
    logic [31:0] flt;
    logic [31:0] od;
    logic [31:0] irq;
    logic [31:0] md;
  } poc_ctrl_s;
endpackage

// ---- rtl/poc_top.sv ----
// Pin ownership and parallel I/O control, 32 pins, APB register slave.
// Assumes pins arrive unsynchronised; peripherals run on pclk.
// Notes on behaviour
// - Writing one to an ownership-set bit gives that pin to the I/O block.
// - A pin under I/O control feeds logic zero to its peripheral input.
// - The ownership-set register is write-only at offset 0x00, bit n is pin n.
// - Each property has a set, a clear and a read-only status register.
// - Output data has set and clear registers, with data and level status.
// - Change status resets to zero but catches changes after reset.
// - Pin level status resets to zero and then follows the pins.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module poc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  input wire logic [31:0] periph_out,
  input wire logic [31:0] periph_oe,
  output logic [31:0] periph_in,
  output logic pin_change_irq
);
  poc_pkg::poc_ctrl_s ctrl_ff, nxt_ctrl;
  logic [31:0] sync1_ff, sync2_ff, filt_ff, nxt_filt, last_ff, nxt_last;
  logic [31:0] chg_ff, nxt_chg;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [31:0] pout_ff, nxt_pout, poe_ff, nxt_poe, pin_ff, nxt_pin;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff, nxt_irq;
  logic acc, wr, rd, hit;
  logic [31:0] lvl;

  // set wins
  // Apply set and clear masks; set wins when both touch a bit
  function automatic logic [31:0] setclr(input logic [31:0] cur,
      input logic s, input logic c, input logic [31:0] m);
    logic [31:0] r;
    r = cur;
    if (c) begin
      r = r & ~m;
    end
    if (s) begin
      r = r | m;
    end
    return r;
  endfunction

  // Access cycle before the answer: read data is taken here
  assign acc = psel & penable & ~pready_ff;
  assign rd = acc & ~pwrite;
  // Writes land only at the edge where the master sees pready high
  assign wr = psel & penable & pwrite & pready_ff;

  // Pin synchroniser: two stages before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= poc_pkg::RST_ZERO;
      sync2_ff <= poc_pkg::RST_ZERO;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Glitch filter: a level must hold two samples before it passes
  always_comb begin
    nxt_filt = filt_ff;
    for (int i = 0; i < poc_pkg::NPINS; i++) begin
      if (!ctrl_ff.flt[i] || sync2_ff[i] == last_ff[i]) begin
        nxt_filt[i] = sync2_ff[i];
      end
    end
    nxt_last = sync2_ff;
  end
  assign lvl = filt_ff;

  // Register writes and change capture
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ctrl.own = setclr(ctrl_ff.own, wr && paddr == poc_pkg::OFS_OWN_SET,
      wr && paddr == poc_pkg::OFS_OWN_CLR, pwdata);
    nxt_ctrl.oe = setclr(ctrl_ff.oe, wr && paddr == poc_pkg::OFS_OE_SET,
      wr && paddr == poc_pkg::OFS_OE_CLR, pwdata);
    nxt_ctrl.flt = setclr(ctrl_ff.flt, wr && paddr == poc_pkg::OFS_FLT_SET,
      wr && paddr == poc_pkg::OFS_FLT_CLR, pwdata);
    nxt_ctrl.irq = setclr(ctrl_ff.irq, wr && paddr == poc_pkg::OFS_IRQ_SET,
      wr && paddr == poc_pkg::OFS_IRQ_CLR, pwdata);
    nxt_ctrl.md = setclr(ctrl_ff.md, wr && paddr == poc_pkg::OFS_MD_SET,
      wr && paddr == poc_pkg::OFS_MD_CLR, pwdata);
    nxt_ctrl.od = setclr(ctrl_ff.od, wr && paddr == poc_pkg::OFS_OD_SET,
      wr && paddr == poc_pkg::OFS_OD_CLR, pwdata);
    // changes stick; a change in the read cycle survives the clear
    nxt_chg = chg_ff;
    if (rd && paddr == poc_pkg::OFS_CHG_STS) begin
      nxt_chg = poc_pkg::RST_ZERO;
    end
    nxt_chg = nxt_chg | (lvl ^ nxt_filt);
  end

  // Pin and peripheral muxing, registered so outputs come from flops
  always_comb begin
    // Defaults keep every bit assigned on every path
    nxt_pout = poc_pkg::RST_ZERO;
    nxt_poe = poc_pkg::RST_ZERO;
    for (int i = 0; i < poc_pkg::NPINS; i++) begin
      if (ctrl_ff.own[i]) begin
        // Open drain: drive only a low level
        nxt_pout[i] = ctrl_ff.md[i] ? 1'b0 : ctrl_ff.od[i];
        nxt_poe[i] = ctrl_ff.oe[i] & (~ctrl_ff.md[i] | ~ctrl_ff.od[i]);
      end else begin
        nxt_pout[i] = ctrl_ff.md[i] ? 1'b0 : periph_out[i];
        nxt_poe[i] = periph_oe[i] & (~ctrl_ff.md[i] | ~periph_out[i]);
      end
    end
    // owned pins hold peripheral input at zero
    nxt_pin = lvl & ~ctrl_ff.own;
    nxt_irq = |(chg_ff & ctrl_ff.irq);
  end

  // APB answer: one wait state, unmapped read gives zero and error
  always_comb begin
    hit = 1'b1;
    nxt_prdata = poc_pkg::RST_ZERO;
    case (paddr)
      // Status registers are read-only: a write is refused
      poc_pkg::OFS_OWN_STS: begin
        nxt_prdata = ctrl_ff.own;
        hit = ~pwrite;
      end
      poc_pkg::OFS_OE_STS: begin
        nxt_prdata = ctrl_ff.oe;
        hit = ~pwrite;
      end
      poc_pkg::OFS_FLT_STS: begin
        nxt_prdata = ctrl_ff.flt;
        hit = ~pwrite;
      end
      poc_pkg::OFS_OD_STS: begin
        nxt_prdata = ctrl_ff.od;
        hit = ~pwrite;
      end
      // live filtered pin levels, reset to zero with the filter
      poc_pkg::OFS_PIN_STS: begin
        nxt_prdata = lvl;
        hit = ~pwrite;
      end
      poc_pkg::OFS_IRQ_STS: begin
        nxt_prdata = ctrl_ff.irq;
        hit = ~pwrite;
      end
      poc_pkg::OFS_CHG_STS: begin
        nxt_prdata = chg_ff;
        hit = ~pwrite;
      end
      poc_pkg::OFS_MD_STS: begin
        nxt_prdata = ctrl_ff.md;
        hit = ~pwrite;
      end
      poc_pkg::OFS_OWN_SET, poc_pkg::OFS_OWN_CLR, poc_pkg::OFS_OE_SET,
      poc_pkg::OFS_OE_CLR, poc_pkg::OFS_FLT_SET, poc_pkg::OFS_FLT_CLR,
      poc_pkg::OFS_OD_SET, poc_pkg::OFS_OD_CLR, poc_pkg::OFS_IRQ_SET,
      poc_pkg::OFS_IRQ_CLR, poc_pkg::OFS_MD_SET,
      poc_pkg::OFS_MD_CLR: hit = pwrite;
      default: hit = 1'b0;
    endcase
    if (!rd) begin
      nxt_prdata = prdata_ff;
    end
    // One wait state: the answer follows the first access cycle
    nxt_pready = acc;
    nxt_pslverr = acc & ~hit;
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '{own: poc_pkg::RST_OWN, default: poc_pkg::RST_ZERO};
      filt_ff <= poc_pkg::RST_ZERO;
      last_ff <= poc_pkg::RST_ZERO;
      chg_ff <= poc_pkg::RST_ZERO;
      prdata_ff <= poc_pkg::RST_ZERO;
      pout_ff <= poc_pkg::RST_ZERO;
      poe_ff <= poc_pkg::RST_ZERO;
      pin_ff <= poc_pkg::RST_ZERO;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      filt_ff <= nxt_filt;
      last_ff <= nxt_last;
      chg_ff <= nxt_chg;
      prdata_ff <= nxt_prdata;
      pout_ff <= nxt_pout;
      poe_ff <= nxt_poe;
      pin_ff <= nxt_pin;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff <= nxt_irq;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pin_out = pout_ff;
  assign pin_oe = poe_ff;
  assign periph_in = pin_ff;
  assign pin_change_irq = irq_ff;
endmodule
`default_nettype wire

// ---- sim/poc_checker.sv ----
// Bus and ownership assertions for the pin control block.
// Bound into poc_top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module poc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] periph_in
);
  logic [31:0] own_ff;
  logic [31:0] nxt_own;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Ownership shadow; updates at the same edge as the block
  always_comb begin
    nxt_own = own_ff;
    if (psel && penable && pready && pwrite && !pslverr) begin
      if (paddr == 8'h00) nxt_own = own_ff | pwdata;
      if (paddr == 8'h04) nxt_own = own_ff & ~pwdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) own_ff <= poc_pkg::RST_OWN;
    else own_ff <= nxt_own;
  end
  access_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("ready not one cycle into access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_cause_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  err_pulse_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  set_readback_a: assert property (
    pready && !pwrite && paddr == 8'h00 |-> pslverr)
    else $error("write-only set register was readable");
  own_status_a: assert property (
    pready && !pwrite && paddr == 8'h08 |-> !pslverr && prdata == own_ff)
    else $error("ownership status wrong");
  periph_zero_a: assert property (
    (periph_in & own_ff & $past(own_ff, 2)) == 32'h0000_0000)
    else $error("peripheral input live on owned pin");
  rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("read data moved without a read");
endmodule
bind poc_top poc_checker poc_checker_inst (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .periph_in);
`default_nettype wire

// ---- sim/poc_far.sv ----
// Pins and peripherals outside the pin control block.
// Driven pins read back their drive; undriven ones follow ext.
`timescale 1ns/1ps
`default_nettype none
module poc_far (
  input wire logic pclk,
  input wire logic [31:0] ext,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  output logic [31:0] pin_in,
  output logic [31:0] periph_out,
  output logic [31:0] periph_oe
);
  logic [31:0] pat_ff = 32'h0F0F_5A5A;
  // Peripherals change every cycle so stale values never pass
  always_ff @(posedge pclk) begin
    pat_ff <= {pat_ff[30:0], pat_ff[31] ^ pat_ff[21]};
  end
  assign periph_out = pat_ff;
  assign periph_oe = {pat_ff[15:0], pat_ff[31:16]};
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule
`default_nettype wire

// ---- sim/pin_ownership_control_tb.sv ----
// Self-checking bench for the pin control block over APB.
// Assumes poc_top, poc_far and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module pin_ownership_control_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr, base;
  logic [31:0] pwdata, prdata, pin_in, pin_out, pin_oe, pout, poe;
  logic [31:0] pin2p, ext, rnd, a, b;
  logic [32:0] exp_q[$], msk_q[$], e;
  logic [64:0] out_q[$], f;
  logic look_ff;
  int errors, comparisons, n;
  poc_top poc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
    .pin_oe, .periph_out(pout), .periph_oe(poe), .periph_in(pin2p),
    .pin_change_irq(irq));
  poc_far poc_far_inst (.pclk, .ext, .pin_out, .pin_oe, .pin_in,
    .periph_out(pout), .periph_oe(poe));
  always #25 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // One transfer; ex and m give the expected {pslverr, prdata}
  task automatic xfer(input logic w, input logic [7:0] ad,
      input logic [31:0] d, input logic [32:0] ex, input logic [32:0] m);
    @(posedge pclk);
    exp_q.push_back(ex);
    msk_q.push_back(m);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (!pready && n < 20);
    if (!pready) begin errors++; complete_run(); end
    {psel, penable} <= 2'b00;
  endtask
  // Note expected {irq, pin_oe, pin_out}; the watcher compares next edge
  task automatic look(input logic [64:0] ex);
    @(posedge pclk);
    out_q.push_back(ex);
    look_ff <= 1'b1;
    @(posedge pclk);
    look_ff <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, 33'h0_0000_0000, 33'h1_0000_0000);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b0, ad, 32'h0000_0000, {1'b0, d}, 33'h1_FFFF_FFFF);
  endtask
  // Oldest expectation meets each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      comparisons++;
      if (((({pslverr, prdata} ^ e) & msk_q.pop_front())) !== 33'h0) begin
        errors++;
        $display("[FAIL] reg %h exp %h got %h", paddr, e, {pslverr, prdata});
      end
    end
    if (look_ff) begin
      f = out_q.pop_front();
      comparisons++;
      if ({irq, pin_oe, pin_out} !== f) begin
        errors++;
        $display("[FAIL] pins exp %h got %h", f, {irq, pin_oe, pin_out});
      end
    end
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, look_ff} = '0;
    {ext, errors, comparisons} = '0;
    rnd = 32'h0000_5273;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, poc_pkg::RST_OWN);
    xfer(1'b0, 8'h00, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    xfer(1'b0, 8'h0C, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    rd(8'h18, 32'h0000_0000);
    // Random hand-over: zero bits leave ownership alone
    a = xs(rnd);
    b = xs(a);
    wr(8'h04, a);
    rd(8'h08, ~a);
    wr(8'h00, b);
    rd(8'h08, ~a | b);
    // Every set, clear and status triple from 0x10 to 0x58, clear overlapping set
    for (int i = 0; i < 5; i++) begin
      rnd = xs(rnd ^ b);
      base = 8'(16 * i + 16);
      wr(base, rnd);
      wr(base + 8'h04, rnd >> 3);
      rd(base + 8'h08, rnd & ~(rnd >> 3));
    end
    for (int i = 1; i < 6; i++) wr(8'(16 * i + 4), 32'hFFFF_FFFF);
    wr(8'h00, 32'hFFFF_FFFF);
    xfer(1'b1, 8'h08, a, 33'h1_0000_0000, 33'h1_0000_0000);
    rd(8'h08, 32'hFFFF_FFFF);
    // Owned pins drive output data; open drain drives only lows
    wr(8'h10, a);
    wr(8'h30, b);
    look({1'b0, a, b});
    wr(8'h50, 32'hFFFF_FFFF);
    look({1'b0, a & ~b, 32'h0000_0000});
    wr(8'h54, 32'hFFFF_FFFF);
    wr(8'h14, 32'hFFFF_FFFF);
    // Pin levels and change capture with pins undriven
    ext <= a;
    repeat (8) @(posedge pclk);
    rd(8'h3C, a);
    xfer(1'b0, 8'h4C, 32'h0, 33'h0_0000_0000, 33'h1_0000_0000);
    ext <= b;
    repeat (8) @(posedge pclk);
    rd(8'h4C, a ^ b);
    rd(8'h3C, b);
    // Enabled change flags raise the interrupt line
    wr(8'h40, 32'hFFFF_FFFF);
    look({1'b0, 32'h0000_0000, b});
    ext <= a;
    repeat (8) @(posedge pclk);
    look({1'b1, 32'h0000_0000, b});
    complete_run();
  end
endmodule
`default_nettype wire
